// ==== qdbi_pkg.sv ====
// Constants and carrier types for the quad DAC host controller.
// Assumes one 50 MHz system clock; the DAC latches are level-triggered.
//
// Overview of operation
// - A channel select goes low only during an accepted write aimed at the DAC.
// - In decoded mode the two low address bits pick one of four selects.
// - In one-line-per-channel mode several selects may fall in one write.
// - Address bit 0 is the lowest word bit, so word N selects channel N+1.
// - On a 16-bit bus the code is the top twelve or the low twelve data bits.
// - The data drive toward the DAC is enabled only while it is addressed.
// - On an 8-bit bus the first byte is held and joined with the second.
// - On an 8-bit bus the DAC loads only on the second, completing write.
// - While not addressed the DAC data lines sit at a fixed all-ones level.
// - A 12-bit successive-approximation search runs on one channel.
// - Writes to the other three channels proceed during a search.
// - Every select pulse stays low for at least 400 ns.
package qdbi_pkg;

  localparam int CLK_NS   = 20;
  localparam int TCS_NS   = 400;
  localparam int CMP_NS   = 15000;
  localparam int TCS_CYC  = (TCS_NS + CLK_NS - 1) / CLK_NS;
  // Rounded down and one short so twelve trials take 180 us on an idle bus
  localparam int CMP_CYC  = CMP_NS / CLK_NS - 1;

  localparam int CODE_W   = 12;
  localparam int BYTE_W   = 8;
  localparam int DATA_W   = 16;
  localparam int NCHAN    = 4;
  localparam int NIB_LSB  = 0;
  localparam int LEFT_LSB = DATA_W - CODE_W;

  localparam logic [CODE_W-1:0] IDLE_CODE = 12'hfff;
  localparam logic [CODE_W-1:0] SAR_MSB   = 12'h800;
  localparam logic [NCHAN-1:0]  SEL_IDLE  = 4'hf;

  typedef struct packed {
    logic [NCHAN-1:0]  addr;
    logic [DATA_W-1:0] data;
  } qdbi_cmd_t;

  typedef struct packed {
    logic bus8;
    logic left_just;
    logic onehot;
  } qdbi_cfg_t;

endpackage

// ==== qdbi_sar.sv ====
// Successive-approximation sequencer driving one DAC channel.
// Assumes a synchronised comparator level and a load acknowledge pulse.
`timescale 1ns/100ps
module qdbi_sar
  import qdbi_pkg::*;
#(
  parameter int SETTLE_CYC = CMP_CYC
) (
  input  wire logic              clk_i,       // System clock
  input  wire logic              rst_i,       // Synchronous reset
  input  wire logic              start_i,     // Start pulse
  input  wire logic              above_i,     // Input above DAC level
  input  wire logic              ack_i,       // Trial load accepted
  output logic                   load_req_o,  // Trial load wanted
  output logic [CODE_W-1:0]      code_o,      // Trial code
  output logic                   busy_o,      // Search running
  output logic                   done_o,      // Result valid pulse
  output logic [CODE_W-1:0]      result_o     // Converted code
);

  initial begin
    if (SETTLE_CYC < 1 || SETTLE_CYC > 1023) begin
      $error("SETTLE_CYC out of range");
    end
  end

  typedef enum logic [1:0] {SAR_IDLE, SAR_REQ, SAR_WAIT} qdbi_sar_st_t;

  qdbi_sar_st_t      st_r, st_nxt;
  logic [CODE_W-1:0] trial_r, bit_r;
  logic [9:0]        cnt_r;
  logic              done_r;
  logic [CODE_W-1:0] res_r;

  wire               last_bit = bit_r[0];
  wire [CODE_W-1:0]  kept     = above_i ? trial_r : (trial_r & ~bit_r);
  wire [CODE_W-1:0]  next_bit = bit_r >> 1;

  assign load_req_o = (st_r == SAR_REQ);
  assign code_o     = trial_r;
  assign busy_o     = (st_r != SAR_IDLE);
  assign done_o     = done_r;
  assign result_o   = res_r;

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      SAR_IDLE: if (start_i) st_nxt = SAR_REQ;
      SAR_REQ:  if (ack_i) st_nxt = SAR_WAIT;
      SAR_WAIT: if (cnt_r == '0) st_nxt = last_bit ? SAR_IDLE : SAR_REQ;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // binary search
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r    <= SAR_IDLE;
      trial_r <= '0;
      bit_r   <= '0;
      cnt_r   <= '0;
      done_r  <= 1'b0;
      res_r   <= '0;
    end else begin
      st_r   <= st_nxt;
      done_r <= 1'b0;
      if (st_r == SAR_IDLE && start_i) begin
        trial_r <= SAR_MSB;
        bit_r   <= SAR_MSB;
      end
      if (st_r == SAR_REQ && ack_i) begin
        cnt_r <= 10'(SETTLE_CYC - 1);
      end
      if (st_r == SAR_WAIT) begin
        if (cnt_r != '0) begin
          cnt_r <= cnt_r - 10'h001;
        end else begin
          trial_r <= kept | next_bit;
          bit_r   <= next_bit;
          if (last_bit) begin
            res_r  <= kept;
            done_r <= 1'b1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_sar_settle_time: assert property (
    (st_r == SAR_REQ && ack_i) |=> !load_req_o [*8])
    else $error("trial reloaded before settling");

  chk_sar_start_msb: assert property (
    (st_r == SAR_IDLE && start_i) |=> (code_o == SAR_MSB && load_req_o))
    else $error("search does not start at mid scale");

  cov_sar_done: cover property (done_o);

endmodule // qdbi_sar

// ==== qdbi_host.sv ====
// Host-side controller for a quad 12-bit level-latched DAC.
// Assumes the DAC data pins and four active-low selects are wired directly,
// and a comparator output arrives asynchronously on COMP_I.
`timescale 1ns/100ps
module qdbi_host
  import qdbi_pkg::*;
#(
  parameter int                 SETTLE_CYC = CMP_CYC,
  parameter int                 SEL_CYC    = TCS_CYC,
  parameter logic [NCHAN-1:0]   SAR_CHAN   = 4'h1
) (
  input  wire logic              CLK_SYS_I,            // 50 MHz clock
  input  wire logic              SYS_RST_I,            // Sync reset, high
  input  wire qdbi_cfg_t         CFG_I,                // Bus width, layout
  input  wire logic              REQ_I,                // Write request
  input  wire qdbi_cmd_t         CMD_I,                // Address and data
  output logic                   RDY_O,                // Ready to take a write
  input  wire logic              SAR_START_I,          // Start conversion
  input  wire logic              COMP_I,               // Comparator pin
  output logic                   SAR_BUSY_O,           // Conversion running
  output logic                   SAR_DONE_O,           // Result pulse
  output logic [CODE_W-1:0]      SAR_RESULT_O,         // Converted code
  output logic [NCHAN-1:0]       CHANNEL_SELECT_N_O,   // Bit0 is channel one
  output logic [CODE_W-1:0]      DAC_DATA_O,           // DAC data pins
  output logic                   DAC_DATA_OE_O         // Data drive enabled
);

  initial begin
    if (SEL_CYC < TCS_CYC || SEL_CYC > 31) begin
      $error("SEL_CYC below select minimum or too wide");
    end
    if ($countones(SAR_CHAN) != 1) begin
      $error("SAR_CHAN must name one channel");
    end
    if (SETTLE_CYC <= SEL_CYC + 2) begin
      $error("SETTLE_CYC must outlast one access");
    end
  end

  typedef enum logic [1:0] {ACC_IDLE, ACC_LOAD, ACC_HOLD} qdbi_acc_st_t;

  ////////////////////////////////////////////////////////////////////////////
  // Comparator synchroniser
  logic comp_meta_r, comp_sync_r;

  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      comp_meta_r <= 1'b0;
      comp_sync_r <= 1'b0;
    end else begin
      comp_meta_r <= COMP_I;
      comp_sync_r <= comp_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Search sequencer
  logic              sar_req, sar_busy, sar_ack;
  logic [CODE_W-1:0] sar_code;

  qdbi_sar #(
    .SETTLE_CYC (SETTLE_CYC)
  ) u_sar (
    .clk_i      (CLK_SYS_I),
    .rst_i      (SYS_RST_I),
    .start_i    (SAR_START_I),
    .above_i    (comp_sync_r),
    .ack_i      (sar_ack),
    .load_req_o (sar_req),
    .code_o     (sar_code),
    .busy_o     (sar_busy),
    .done_o     (SAR_DONE_O),
    .result_o   (SAR_RESULT_O)
  );

  assign SAR_BUSY_O = sar_busy;

  ////////////////////////////////////////////////////////////////////////////
  // Request decode
  qdbi_acc_st_t      st_r;
  logic [4:0]        cnt_r;
  logic              byte_phase_r;
  logic [BYTE_W-1:0] byte_lo_r;
  logic [NCHAN-1:0]  sel_n_r;
  logic [CODE_W-1:0] data_r;
  logic              oe_r;

  wire              acc_idle  = (st_r == ACC_IDLE);
  // Search trials take the bus first; user writes wait one access at most
  assign sar_ack = acc_idle && sar_req;
  assign RDY_O   = acc_idle && !sar_req;
  wire              user_take = REQ_I && RDY_O;

  wire [NCHAN-1:0]  dec_mask  = 4'h1 << CMD_I.addr[1:0];
  wire [NCHAN-1:0]  raw_mask  = CFG_I.onehot ? CMD_I.addr : dec_mask;
  wire [NCHAN-1:0]  usr_mask  = raw_mask & ~(sar_busy ? SAR_CHAN : 4'h0);

  wire [CODE_W-1:0] wide_code = CFG_I.left_just
                                ? CMD_I.data[DATA_W-1:LEFT_LSB]
                                : CMD_I.data[CODE_W-1:0];
  wire [CODE_W-1:0] byte_code = {CMD_I.data[NIB_LSB+3:NIB_LSB], byte_lo_r};
  wire [CODE_W-1:0] usr_code  = CFG_I.bus8 ? byte_code : wide_code;

  wire              first_byte = CFG_I.bus8 && !byte_phase_r;
  wire              usr_load  = user_take && !first_byte && (usr_mask != '0);
  wire              start_acc = sar_ack || usr_load;
  wire [NCHAN-1:0]  acc_mask  = sar_ack ? SAR_CHAN : usr_mask;
  wire [CODE_W-1:0] acc_code  = sar_ack ? sar_code : usr_code;

  ////////////////////////////////////////////////////////////////////////////
  // Byte holding latch
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      byte_phase_r <= 1'b0;
      byte_lo_r    <= '0;
    end else if (user_take && CFG_I.bus8) begin
      byte_phase_r <= !byte_phase_r;
      if (first_byte) begin
        byte_lo_r <= CMD_I.data[BYTE_W-1:0];
      end
    end else if (!CFG_I.bus8) begin
      byte_phase_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer: select low SEL_CYC cycles, then one hold cycle
  qdbi_acc_st_t      st_nxt;
  logic [4:0]        cnt_nxt;
  logic [NCHAN-1:0]  sel_n_nxt;
  logic [CODE_W-1:0] data_nxt;
  logic              oe_nxt;

  always_comb begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    sel_n_nxt = sel_n_r;
    data_nxt  = data_r;
    oe_nxt    = oe_r;
    unique case (st_r)
      ACC_IDLE: if (start_acc) begin
        st_nxt    = ACC_LOAD;
        sel_n_nxt = ~acc_mask;
        data_nxt  = acc_code;
        oe_nxt    = 1'b1;
        cnt_nxt   = 5'(SEL_CYC - 1);
      end
      ACC_LOAD: if (cnt_r == '0) begin
        st_nxt    = ACC_HOLD;
        sel_n_nxt = SEL_IDLE;
      end else begin
        cnt_nxt = cnt_r - 5'h01;
      end
      ACC_HOLD: begin
        st_nxt   = ACC_IDLE;
        data_nxt = IDLE_CODE;
        oe_nxt   = 1'b0;
      end
      default: begin
        // Stray code: release the bus rather than hang low
        st_nxt    = ACC_IDLE;
        sel_n_nxt = SEL_IDLE;
        data_nxt  = IDLE_CODE;
        oe_nxt    = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      st_r    <= ACC_IDLE;
      cnt_r   <= '0;
      sel_n_r <= SEL_IDLE;
      data_r  <= IDLE_CODE;
      oe_r    <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      sel_n_r <= sel_n_nxt;
      data_r  <= data_nxt;
      oe_r    <= oe_nxt;
    end
  end

  assign CHANNEL_SELECT_N_O = sel_n_r;
  assign DAC_DATA_O         = data_r;
  assign DAC_DATA_OE_O      = oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);

  logic [5:0] low_cnt_r;
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I || sel_n_r == SEL_IDLE) begin
      low_cnt_r <= '0;
    end else if (low_cnt_r != 6'h3f) begin
      low_cnt_r <= low_cnt_r + 6'h01;
    end
  end

  chk_sel_pulse_width: assert property (
    $rose(&sel_n_r) |-> (low_cnt_r == 6'(SEL_CYC)))
    else $error("select pulse not of the set width");

  chk_sel_needs_oe: assert property (
    (sel_n_r != SEL_IDLE) |-> oe_r)
    else $error("select low without data drive");

  chk_idle_data_level: assert property (
    !oe_r |-> (data_r == IDLE_CODE))
    else $error("data not at idle level while unaddressed");

  chk_decode_one_sel: assert property (
    (usr_load && !CFG_I.onehot && !sar_busy) |=>
      (sel_n_r == ~(4'h1 << $past(CMD_I.addr[1:0]))))
    else $error("decoded select does not follow address");

  chk_first_byte_noload: assert property (
    (user_take && first_byte) |=> (sel_n_r == SEL_IDLE))
    else $error("first byte loaded the DAC");

  chk_byte_join: assert property (
    (usr_load && CFG_I.bus8 && !sar_ack) |=>
      (data_r == {$past(CMD_I.data[3:0]), $past(byte_lo_r)}))
    else $error("byte pair not joined low byte first");

  chk_wide_just: assert property (
    (usr_load && !CFG_I.bus8 && CFG_I.left_just) |=>
      (data_r == $past(CMD_I.data[DATA_W-1:LEFT_LSB])))
    else $error("left justified code misplaced");

  chk_sar_chan_fenced: assert property (
    (usr_load && sar_busy) |=> ((~sel_n_r & SAR_CHAN) == '0))
    else $error("user write reached search channel");

  chk_sel_only_on_take: assert property (
    ((sel_n_r == SEL_IDLE) && !start_acc) |=> (sel_n_r == SEL_IDLE))
    else $error("select fell without a write");

  chk_right_just: assert property (
    (usr_load && !CFG_I.bus8 && !CFG_I.left_just) |=>
      (data_r == $past(CMD_I.data[CODE_W-1:0])))
    else $error("right justified code misplaced");

  chk_onehot_mask: assert property (
    (usr_load && CFG_I.onehot && !sar_busy) |=>
      (sel_n_r == ~$past(CMD_I.addr)))
    else $error("channel mask not applied as given");

  chk_word_addr_lsb: assert property (
    (usr_load && !CFG_I.onehot && CMD_I.addr[0]) |=>
      (sel_n_r[0] && sel_n_r[2]))
    else $error("odd word address reached an odd channel");

  chk_fall_needs_take: assert property (
    ((sel_n_r != SEL_IDLE) && ($past(sel_n_r) == SEL_IDLE)) |->
      $past(start_acc))
    else $error("select fell with no accepted write");

  chk_data_steady_sel: assert property (
    ($past(sel_n_r) != SEL_IDLE) |-> $stable(data_r))
    else $error("data moved while a select was low");

  chk_low_byte_held: assert property (
    (user_take && first_byte) |=>
      (byte_lo_r == $past(CMD_I.data[BYTE_W-1:0])))
    else $error("first byte not held as the low byte");

  chk_trial_on_chan: assert property (
    sar_ack |=> ((sel_n_r == ~SAR_CHAN) && (data_r == $past(sar_code))))
    else $error("search trial not loaded on its channel");

  chk_oe_off_idle: assert property (
    (st_r == ACC_IDLE) |-> !oe_r)
    else $error("data drive left on while unaddressed");

  chk_empty_no_pulse: assert property (
    (user_take && !first_byte && (usr_mask == '0)) |=>
      (sel_n_r == SEL_IDLE))
    else $error("empty mask write pulsed a select");

  chk_done_ends_busy: assert property (
    SAR_DONE_O |-> !sar_busy)
    else $error("result flagged while search still busy");

  cov_multi_select: cover property (usr_load && $countones(usr_mask) > 1);
  cov_byte_pair: cover property (usr_load && CFG_I.bus8);
  cov_write_during_sar: cover property (usr_load && sar_busy);
  cov_left_just: cover property (usr_load && CFG_I.left_just);

endmodule // qdbi_host

// ==== qdbi_dac_model.sv ====
// Behavioural quad DAC: four level-latched channels and a comparator.
// Assumes selects and data come straight from the host controller.
`timescale 1ns/100ps
module qdbi_dac_model
  import qdbi_pkg::*;
#(
  parameter int REF_MV = -10000
) (
  input  wire logic [NCHAN-1:0]   sel_n_i,  // Active-low selects
  input  wire logic [CODE_W-1:0]  data_i,   // Shared data bus
  input  wire logic [15:0]        vin_mv_i, // Unknown input in mV
  output logic [NCHAN*CODE_W-1:0] lat_o,    // Latched codes
  output logic                    comp_o    // Input above channel one
);
  int vout_mv;

  always @(sel_n_i or data_i) begin
    for (int k = 0; k < NCHAN; k++) begin
      if (sel_n_i[k] == 1'b0) begin
        lat_o[k*CODE_W +: CODE_W] = data_i;
      end
    end
  end

  always_comb begin
    vout_mv = -REF_MV * int'(lat_o[CODE_W-1:0]) / 4096;
    comp_o  = int'(vin_mv_i) > vout_mv;
  end
endmodule // qdbi_dac_model

// ==== qdbi_host_tb.sv ====
// Self-checking bench for the quad DAC host controller.
// Assumes the behavioural DAC model stands on the select and data pins.
`timescale 1ns/100ps
module qdbi_host_tb
  import qdbi_pkg::*;
;
  // Settle outlasts one access so user writes fit between trials
  localparam int SETTLE = 30;
  localparam int LIMIT  = 20000;
  logic                    clk   = 1'b0;
  logic                    rst   = 1'b1;
  qdbi_cfg_t               cfg   = '0;
  logic                    req   = 1'b0;
  qdbi_cmd_t               cmd   = '0;
  logic                    start = 1'b0;
  logic [15:0]             vin   = 16'h0000;
  logic                    rdy, busy, done, oe, comp;
  logic [CODE_W-1:0]       result, dat;
  logic [NCHAN-1:0]        sel_n;
  logic [NCHAN*CODE_W-1:0] lat;
  int                      errors = 0;
  int                      num_checks = 0;
  int                      cycles = 0;

  always #10 clk = ~clk;

  qdbi_host #(.SETTLE_CYC(SETTLE), .SEL_CYC(TCS_CYC), .SAR_CHAN(4'h1)) u_dut (
    .CLK_SYS_I(clk), .SYS_RST_I(rst), .CFG_I(cfg), .REQ_I(req), .CMD_I(cmd),
    .RDY_O(rdy), .SAR_START_I(start), .COMP_I(comp), .SAR_BUSY_O(busy),
    .SAR_DONE_O(done), .SAR_RESULT_O(result), .CHANNEL_SELECT_N_O(sel_n),
    .DAC_DATA_O(dat), .DAC_DATA_OE_O(oe));

  qdbi_dac_model u_dac (
    .sel_n_i(sel_n), .data_i(dat), .vin_mv_i(vin), .lat_o(lat),
    .comp_o(comp));

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors = errors + 1;
      summarize();
    end
  end

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [CODE_W-1:0] lane(input int k);
    return lat[k*CODE_W +: CODE_W];
  endfunction

  // Request held until taken at an edge with ready high
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= 1'b1;
    cmd <= '{addr: a, data: d};
    do begin
      @(negedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 5000);
    @(posedge clk);
    req <= 1'b0;
  endtask

  task automatic load(input logic [3:0] esel, input logic [11:0] ecode);
    int n;
    n = 0;
    while (sel_n === SEL_IDLE && n < 40) begin
      @(negedge clk);
      n++;
    end
    check("select", sel_n, esel);
    check("data", dat, ecode);
    check("drive", oe, 1'b1);
    n = 0;
    while (sel_n !== SEL_IDLE && n < 200) begin
      @(negedge clk);
      n++;
    end
    check("width ok", n >= TCS_CYC, 1'b1);
    @(negedge clk);
    check("idle data", dat, IDLE_CODE);
    check("idle drive", oe, 1'b0);
  endtask

  task automatic quiet(input int cyc);
    logic seen;
    seen = 1'b0;
    repeat (cyc) @(negedge clk) if (sel_n !== SEL_IDLE) seen = 1'b1;
    check("no pulse", seen, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check("reset sel", sel_n, SEL_IDLE);
    check("reset data", dat, IDLE_CODE);
    check("reset drive", oe, 1'b0);
    check("reset ready", rdy, 1'b1);
  endtask

  task automatic t_decode();
    for (int a = 0; a < NCHAN; a++) begin
      wr(a[3:0], 16'hf5a0 + 16'(a));
      load(~(4'h1 << a), 12'h5a0 + 12'(a));
      check("latch", lane(a), 12'h5a0 + 12'(a));
    end
  endtask

  task automatic t_left();
    @(posedge clk);
    cfg <= 3'b010; // Left-justified, decoded
    wr(4'h1, 16'habc7);
    load(4'hd, 12'habc);
  endtask

  task automatic t_onehot();
    @(posedge clk);
    cfg <= 3'b001; // Channel mask
    wr(4'h5, 16'h0777);
    load(4'ha, 12'h777);
    check("lane one", lane(0), 12'h777);
    check("lane three", lane(2), 12'h777);
    wr(4'h0, 16'h0111);
    quiet(30);
    check("kept one", lane(0), 12'h777);
    check("kept three", lane(2), 12'h777);
  endtask

  task automatic t_bus8();
    @(posedge clk);
    cfg <= 3'b100; // Byte bus, decoded
    wr(4'h3, 16'hff34);
    quiet(6);
    wr(4'h3, 16'hff02);
    load(4'h7, 12'h234);
    check("byte latch", lane(3), 12'h234);
  endtask

  task automatic t_sar();
    logic [CODE_W-1:0] e;
    int t, n;
    e = '0;
    for (int b = CODE_W - 1; b >= 0; b--) begin
      t = int'(e | (12'h001 << b));
      if (3456 > 10000 * t / 4096) e = 12'(t);
    end
    @(posedge clk);
    cfg   <= 3'b000;
    vin   <= 16'd3456;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(negedge clk);
    check("busy", busy, 1'b1);
    wr(4'h2, 16'h0555);
    load(4'hb, 12'h555);
    check("write in search", busy, 1'b1);
    n = 0;
    while (done !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    check("done", done, 1'b1);
    check("result", result, e);
    check("busy off", busy, 1'b0);
    check("other chan", lane(2), 12'h555);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    t_reset();
    t_decode();
    t_left();
    t_onehot();
    t_bus8();
    t_sar();
    summarize();
  end
endmodule // qdbi_host_tb
